// ### design/defc_defs.vh
// shared constants of the dma error flag collector
`ifndef DEFC_DEFS_VH
`define DEFC_DEFS_VH
// register word offsets (byte addresses)
`define DEFC_ADDR_W 8
`define DEFC_OFF_MISS_LO 8'h00
`define DEFC_OFF_MISS_HI 8'h04
`define DEFC_OFF_MCLR_LO 8'h08
`define DEFC_OFF_MCLR_HI 8'h0c
`define DEFC_OFF_QMISS 8'h10
`define DEFC_OFF_QMCLR 8'h14
`define DEFC_OFF_CONTROLLER_ERROR_FLAGS 8'h18
`define DEFC_OFF_CCCLR 8'h1c
`define DEFC_OFF_ERROR_REEVALUATE_BIT 8'h20
`define DEFC_OFF_PRIO 8'h24
`define DEFC_OFF_QSTAT0 8'h28
`define DEFC_OFF_QSTAT1 8'h2c
`define DEFC_OFF_QSTAT2 8'h30
// field positions, counts and widths
`define DEFC_TCC_BIT 16
`define DEFC_NQ 3
`define DEFC_NCH 64
`define DEFC_NQCH 8
`define DEFC_PRIO_W 3
`define DEFC_QCNT_W 5
`define DEFC_THR_BIT 8
`define DEFC_CNT_W 7
// limits and reset values
`define DEFC_TCC_MAX 7'h3f
`define DEFC_PRIO_RST 3'h0
`define DEFC_ZERO32 32'h0
`endif

// ### design/defc_irq_gen.v
// error interrupt pulse generator
`timescale 1ns/1ns
module defc_irq_gen (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // or of all error flags, next value
  input wire any_err_d,
  // reevaluate request
  input wire reeval,
  // interrupt pulse
  output reg err_irq
);
  reg any_err_q; // registered or of flags
  // pulse on rising edge of the or, or on reevaluate with flags set
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      any_err_q <= 1'b0;
      err_irq <= 1'b0;
    end else begin
      any_err_q <= any_err_d;
      err_irq <= (any_err_d & ~any_err_q)
        | (reeval & any_err_q);
    end
  end
endmodule // defc_irq_gen

// ### design/defc_top.v
// dma error flag collector: missed-event, threshold and completion-code flags
// Behaviour
// - hold 3-bit queue 0 priority, 0 highest
// - every error flag feeds error interrupt
// - second event before service sets missed flag
// - manual, chained, hardware triggers tracked separately
// - null entry also sets channel missed flag
// - interrupt when flags go from none, or on evaluate write with flags set
// - missed flags in low and high words
// - missed flag held until write-one clear
// - queued channel repeat trigger sets its flag
// - queued channel null entry sets its flag
// - queued flag cleared only by write-one
// - queue count reaching watermark sets threshold bit
// - over 63 outstanding completion codes sets bit 16
// - controller flags cleared only by clear register
// - flags read-only reset zero, clears write-only
// - threshold clear also clears queue status fields
// - evaluate write pulses interrupt if flags remain
`timescale 1ns/1ns
`include "defc_defs.vh"
module defc_top (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // register port
  input wire [`DEFC_ADDR_W-1:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // dma channel triggers
  input wire [`DEFC_NCH-1:0] dma_trig_manual,
  input wire [`DEFC_NCH-1:0] dma_trig_chain,
  input wire [`DEFC_NCH-1:0] dma_trig_hw,
  input wire [`DEFC_NCH-1:0] dma_svc_manual,
  input wire [`DEFC_NCH-1:0] dma_svc_chain,
  input wire [`DEFC_NCH-1:0] dma_svc_hw,
  input wire [`DEFC_NCH-1:0] dma_null_hit,
  // queued channel triggers
  input wire [`DEFC_NQCH-1:0] qch_trig,
  input wire [`DEFC_NQCH-1:0] qch_svc,
  input wire [`DEFC_NQCH-1:0] qch_null_hit,
  // event queue occupancy and watermarks, three queues packed
  input wire [`DEFC_NQ*`DEFC_QCNT_W-1:0] queue_count,
  input wire [`DEFC_NQ*`DEFC_QCNT_W-1:0] queue_watermark_config,
  // completion code tracking: request issued or returned
  input wire tcc_issue,
  input wire tcc_return,
  // priority to transfer engine 0
  output wire [`DEFC_PRIO_W-1:0] queue0_priority,
  // error interrupt pulse
  output wire err_irq
);
  // reset synchroniser
  reg rst_meta_q;
  reg rst_n_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // decoded write strobes
  wire wr_mclr_lo = reg_wr && (reg_addr == `DEFC_OFF_MCLR_LO);
  wire wr_mclr_hi = reg_wr && (reg_addr == `DEFC_OFF_MCLR_HI);
  wire wr_qmclr = reg_wr && (reg_addr == `DEFC_OFF_QMCLR);
  wire wr_ccclr = reg_wr && (reg_addr == `DEFC_OFF_CCCLR);
  wire wr_error_reevaluate_bit = reg_wr && (reg_addr == `DEFC_OFF_ERROR_REEVALUATE_BIT);
  wire wr_prio = reg_wr && (reg_addr == `DEFC_OFF_PRIO);

  // clear masks from write-one bits
  wire [`DEFC_NCH-1:0] miss_clr = {wr_mclr_hi ? reg_wdata : `DEFC_ZERO32,
    wr_mclr_lo ? reg_wdata : `DEFC_ZERO32};
  wire [`DEFC_NQCH-1:0] qmiss_clr = wr_qmclr ? reg_wdata[`DEFC_NQCH-1:0]
    : {`DEFC_NQCH{1'b0}};
  wire [`DEFC_NQ-1:0] thr_clr = wr_ccclr ? reg_wdata[`DEFC_NQ-1:0]
    : {`DEFC_NQ{1'b0}};
  wire tcc_clr = wr_ccclr & reg_wdata[`DEFC_TCC_BIT];

  // missed-event detection, dma channels
  wire [`DEFC_NCH-1:0] dma_miss;
  defc_trig_track #(.NCH(`DEFC_NCH)) u_dma_track (
    .clk(clk),
    .rst_n(rst_n_q),
    .trig_manual(dma_trig_manual),
    .trig_chain(dma_trig_chain),
    .trig_hw(dma_trig_hw),
    .svc_manual(dma_svc_manual),
    .svc_chain(dma_svc_chain),
    .svc_hw(dma_svc_hw),
    .null_hit(dma_null_hit),
    .miss(dma_miss)
  );

  // missed-event detection, queued channels, one trigger kind
  wire [`DEFC_NQCH-1:0] qch_miss;
  defc_trig_track #(.NCH(`DEFC_NQCH)) u_qch_track (
    .clk(clk),
    .rst_n(rst_n_q),
    .trig_manual({`DEFC_NQCH{1'b0}}),
    .trig_chain({`DEFC_NQCH{1'b0}}),
    .trig_hw(qch_trig),
    .svc_manual({`DEFC_NQCH{1'b0}}),
    .svc_chain({`DEFC_NQCH{1'b0}}),
    .svc_hw(qch_svc),
    .null_hit(qch_null_hit),
    .miss(qch_miss)
  );

  // sticky flags; set wins over a clear in the same cycle
  reg [`DEFC_NCH-1:0] miss_q;
  reg [`DEFC_NCH-1:0] miss_d;
  reg [`DEFC_NQCH-1:0] qmiss_q;
  reg [`DEFC_NQCH-1:0] qmiss_d;
  reg [`DEFC_NQ-1:0] thr_q;
  reg [`DEFC_NQ-1:0] thr_d;
  reg tcc_err_q;
  reg tcc_err_d;
  // queue status high mark and threshold hit
  reg [`DEFC_NQ*`DEFC_QCNT_W-1:0] hmark_q;
  reg [`DEFC_NQ*`DEFC_QCNT_W-1:0] hmark_d;
  reg [`DEFC_NQ-1:0] thit_q;
  reg [`DEFC_NQ-1:0] thit_d;
  // threshold compare per queue
  wire [`DEFC_NQ-1:0] thr_reach;
  genvar q;
  generate
    for (q = 0; q < `DEFC_NQ; q = q + 1) begin : g_q
      assign thr_reach[q] = queue_count[q*`DEFC_QCNT_W +: `DEFC_QCNT_W]
        >= queue_watermark_config[q*`DEFC_QCNT_W +: `DEFC_QCNT_W];
    end
  endgenerate

  // outstanding completion code counter
  reg [`DEFC_CNT_W-1:0] tcc_cnt_q;
  reg [`DEFC_CNT_W-1:0] tcc_cnt_d;
  // next counter value, saturates at width limit
  always @* begin
    tcc_cnt_d = tcc_cnt_q;
    if (tcc_issue && !tcc_return && tcc_cnt_q != {`DEFC_CNT_W{1'b1}}) begin
      tcc_cnt_d = tcc_cnt_q + 1'b1;
    end else if (!tcc_issue && tcc_return && tcc_cnt_q != {`DEFC_CNT_W{1'b0}}) begin
      tcc_cnt_d = tcc_cnt_q - 1'b1;
    end
  end

  // next value of all flags
  integer k;
  always @* begin
    miss_d = (miss_q & ~miss_clr) | dma_miss;
    qmiss_d = (qmiss_q & ~qmiss_clr) | qch_miss;
    thr_d = (thr_q & ~thr_clr) | thr_reach;
    tcc_err_d = (tcc_err_q & ~tcc_clr) | (tcc_cnt_q > `DEFC_TCC_MAX);
    hmark_d = hmark_q;
    thit_d = (thit_q & ~thr_clr) | thr_reach;
    for (k = 0; k < `DEFC_NQ; k = k + 1) begin
      // clear high mark on threshold clear, then track peak
      if (thr_clr[k]) begin
        hmark_d[k*`DEFC_QCNT_W +: `DEFC_QCNT_W] = {`DEFC_QCNT_W{1'b0}};
      end
      if (queue_count[k*`DEFC_QCNT_W +: `DEFC_QCNT_W]
          > hmark_d[k*`DEFC_QCNT_W +: `DEFC_QCNT_W]) begin
        hmark_d[k*`DEFC_QCNT_W +: `DEFC_QCNT_W] =
          queue_count[k*`DEFC_QCNT_W +: `DEFC_QCNT_W];
      end
    end
  end

  // flag and status registers
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      miss_q <= {`DEFC_NCH{1'b0}};
      qmiss_q <= {`DEFC_NQCH{1'b0}};
      thr_q <= {`DEFC_NQ{1'b0}};
      tcc_err_q <= 1'b0;
      hmark_q <= {(`DEFC_NQ*`DEFC_QCNT_W){1'b0}};
      thit_q <= {`DEFC_NQ{1'b0}};
      tcc_cnt_q <= {`DEFC_CNT_W{1'b0}};
    end else begin
      miss_q <= miss_d;
      qmiss_q <= qmiss_d;
      thr_q <= thr_d;
      tcc_err_q <= tcc_err_d;
      hmark_q <= hmark_d;
      thit_q <= thit_d;
      tcc_cnt_q <= tcc_cnt_d;
    end
  end

  // queue 0 priority register
  reg [`DEFC_PRIO_W-1:0] prio_q;
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      prio_q <= `DEFC_PRIO_RST;
    end else if (wr_prio) begin
      prio_q <= reg_wdata[`DEFC_PRIO_W-1:0];
    end
  end
  assign queue0_priority = prio_q;

  // interrupt: or of all flags' next values
  wire any_err_d = (|miss_d) | (|qmiss_d) | (|thr_d) | tcc_err_d;
  defc_irq_gen u_irq (
    .clk(clk),
    .rst_n(rst_n_q),
    .any_err_d(any_err_d),
    .reeval(wr_error_reevaluate_bit & reg_wdata[0]),
    .err_irq(err_irq)
  );

  // read mux; clear registers and unmapped read as zero
  reg [31:0] rdata_d;
  always @* begin
    rdata_d = `DEFC_ZERO32;
    case (reg_addr)
      `DEFC_OFF_MISS_LO: rdata_d = miss_q[31:0];
      `DEFC_OFF_MISS_HI: rdata_d = miss_q[63:32];
      `DEFC_OFF_QMISS: rdata_d[`DEFC_NQCH-1:0] = qmiss_q;
      `DEFC_OFF_CONTROLLER_ERROR_FLAGS: begin
        rdata_d[`DEFC_NQ-1:0] = thr_q;
        rdata_d[`DEFC_TCC_BIT] = tcc_err_q;
      end
      `DEFC_OFF_PRIO: rdata_d[`DEFC_PRIO_W-1:0] = prio_q;
      `DEFC_OFF_QSTAT0: begin
        rdata_d[`DEFC_QCNT_W-1:0] = hmark_q[`DEFC_QCNT_W-1:0];
        rdata_d[`DEFC_THR_BIT] = thit_q[0];
      end
      `DEFC_OFF_QSTAT1: begin
        rdata_d[`DEFC_QCNT_W-1:0] = hmark_q[2*`DEFC_QCNT_W-1:`DEFC_QCNT_W];
        rdata_d[`DEFC_THR_BIT] = thit_q[1];
      end
      `DEFC_OFF_QSTAT2: begin
        rdata_d[`DEFC_QCNT_W-1:0] = hmark_q[3*`DEFC_QCNT_W-1:2*`DEFC_QCNT_W];
        rdata_d[`DEFC_THR_BIT] = thit_q[2];
      end
      default: rdata_d = `DEFC_ZERO32;
    endcase
  end

  // read data registered, valid only the cycle after the strobe
  always @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      reg_rdata <= `DEFC_ZERO32;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end else begin
      reg_rdata <= `DEFC_ZERO32;
    end
  end
endmodule // defc_top

// ### design/defc_trig_track.v
// per-channel missed-event detector for several independent trigger kinds
`timescale 1ns/1ns
module defc_trig_track #(
  parameter NCH = 64
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // trigger kinds, one bit per channel
  input wire [NCH-1:0] trig_manual,
  input wire [NCH-1:0] trig_chain,
  input wire [NCH-1:0] trig_hw,
  // service or clear of a pending event per kind
  input wire [NCH-1:0] svc_manual,
  input wire [NCH-1:0] svc_chain,
  input wire [NCH-1:0] svc_hw,
  // null entry met on service
  input wire [NCH-1:0] null_hit,
  // one-cycle miss pulses per channel
  output wire [NCH-1:0] miss
);
  reg [NCH-1:0] pend_m_q; // pending manual
  reg [NCH-1:0] pend_c_q; // pending chained
  reg [NCH-1:0] pend_h_q; // pending hardware
  // pending bits: new trigger sets, service clears, both means still pending
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_m_q <= {NCH{1'b0}};
      pend_c_q <= {NCH{1'b0}};
      pend_h_q <= {NCH{1'b0}};
    end else begin
      pend_m_q <= (pend_m_q & ~svc_manual) | trig_manual;
      pend_c_q <= (pend_c_q & ~svc_chain) | trig_chain;
      pend_h_q <= (pend_h_q & ~svc_hw) | trig_hw;
    end
  end
  // a repeat of a kind still pending is a miss; kinds never mix
  genvar i;
  generate
    for (i = 0; i < NCH; i = i + 1) begin : g_ch
      assign miss[i] = (trig_manual[i] & pend_m_q[i] & ~svc_manual[i])
        | (trig_chain[i] & pend_c_q[i] & ~svc_chain[i])
        | (trig_hw[i] & pend_h_q[i] & ~svc_hw[i])
        | null_hit[i];
    end
  endgenerate
endmodule // defc_trig_track

// ### dv/defc_chk.sv
// port assertions for the error flag collector
`timescale 1ns/1ns
`include "defc_defs.vh"
module defc_chk (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // outputs
  input wire [2:0] queue0_priority,
  input wire err_irq
);
  // decoded accesses
  wire pw = reg_wr && reg_addr == `DEFC_OFF_PRIO;
  wire pr = reg_rd && reg_addr == `DEFC_OFF_PRIO;
  wire er = reg_rd && reg_addr == `DEFC_OFF_CONTROLLER_ERROR_FLAGS;
  wire qr = reg_rd && reg_addr == `DEFC_OFF_QMISS;
  wire wo = reg_rd && reg_addr inside {8'h08, 8'h0c, 8'h14, 8'h1c, 8'h20};
  wire [2:0] wp = reg_wdata[2:0];
  wire [27:0] cz = {reg_rdata[31:17], reg_rdata[15:3]};
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  idle_rdata_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero");
  irq_one_cycle_a: assert property ($rose(err_irq) |-> ##1 !err_irq)
    else $error("irq wider than a cycle");
  prio_hold_a: assert property (!pw |=> $stable(queue0_priority))
    else $error("priority changed");
  prio_load_a: assert property (pw |=> queue0_priority == $past(wp))
    else $error("priority not loaded");
  prio_read_a: assert property (pr |=> reg_rdata == {29'h0, queue0_priority})
    else $error("priority readback");
  ctrl_rsvd_zero_a: assert property (er |=> cz == 28'h0)
    else $error("ctrl reserved bits set");
  qmiss_rsvd_zero_a: assert property (qr |=> reg_rdata[31:8] == 24'h0)
    else $error("queued reserved bits set");
  clear_reads_zero_a: assert property (wo |=> reg_rdata == 32'h0)
    else $error("write-only read not zero");
  // main scenarios
  irq_seen_c: cover property (err_irq);
  tcc_flag_c: cover property (er ##1 reg_rdata[16]);
  prio_write_c: cover property (pw ##1 queue0_priority != 3'h0);
endmodule // defc_chk
bind defc_top defc_chk u_chk (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .queue0_priority(queue0_priority), .err_irq(err_irq));

// ### dv/defc_top_tb.sv
// self-checking bench for the error flag collector
`timescale 1ns/1ns
module defc_top_tb;
  // bus, drives and model state
  logic clk, reset_n, reg_wr, reg_rd, ti, tr;
  logic [7:0] reg_addr, eq;
  logic [31:0] reg_wdata, rs, ec, irq_n, exp_irq, mk;
  logic [63:0] dv [7];
  logic [7:0] qv [3];
  logic [14:0] qcnt, qwm;
  logic [63:0] em;
  wire [31:0] reg_rdata;
  wire [2:0] prio;
  wire irq;
  int error_cnt, n_compared, k, ch, w, i;
  defc_top uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dma_trig_manual(dv[0]),
    .dma_trig_chain(dv[1]), .dma_trig_hw(dv[2]), .dma_svc_manual(dv[3]),
    .dma_svc_chain(dv[4]), .dma_svc_hw(dv[5]), .dma_null_hit(dv[6]), .qch_trig(qv[0]),
    .qch_svc(qv[1]), .qch_null_hit(qv[2]), .queue_count(qcnt), .queue_watermark_config(qwm),
    .tcc_issue(ti), .tcc_return(tr), .queue0_priority(prio), .err_irq(irq));
  // xorshift source
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic chk(logic [31:0] g, logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(reg_rdata & mk, e);
  endtask
  // one-cycle pulse on channel c of drive group g
  task automatic ev(bit q, int g, int c);
    @(posedge clk);
    if (q) qv[g] <= 8'h1 << c;
    else dv[g] <= 64'h1 << c;
    @(posedge clk);
    if (q) qv[g] <= 8'h0;
    else dv[g] <= 64'h0;
  endtask
  // all flag words and the interrupt count
  task automatic cmp_all();
    rd(8'h00, em[31:0]);
    rd(8'h04, em[63:32]);
    rd(8'h10, {24'h0, eq});
    rd(8'h18, ec);
    chk(irq_n, exp_irq);
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // interrupt pulse counter
  always @(posedge clk) if (irq === 1'b1) irq_n <= irq_n + 1;
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
  initial begin
    {reset_n, reg_wr, reg_rd, ti, tr, reg_addr, reg_wdata, qcnt} = '0;
    dv = '{default: 64'h0};
    qv = '{default: 8'h0};
    qwm = 15'h7fff;
    rs = 32'd37118;
    {em, eq, ec, irq_n, exp_irq} = '0;
    mk = '1;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (i = 0; i < 16; i++) rd(8'(i * 4), 32'h0);
    for (i = 0; i < 4; i++) begin
      w = (i == 0) ? 7 : (i == 1) ? 0 : int'(rnd() % 8);
      wr(8'h24, 32'(w));
      rd(8'h24, 32'(w));
    end
    for (k = 0; k < 3; k++) begin
      ch = (k == 0) ? 31 : (k == 1) ? 32 : int'(rnd() % 64);
      ev(0, k, ch);
      ev(0, k + 3, ch);
      ev(0, k, ch);
      ev(0, (k + 1) % 3, ch);
      cmp_all();
      ev(0, k, ch);
      em[ch] = 1'b1;
      exp_irq++;
      cmp_all();
      ev(0, 6, (ch + 1) % 64);
      em[(ch + 1) % 64] = 1'b1;
      cmp_all();
      wr(8'h08, 32'h0);
      wr(8'h0c, 32'h0);
      wr(ch < 32 ? 8'h08 : 8'h0c, 32'h1 << (ch % 32));
      em[ch] = 1'b0;
      cmp_all();
      wr(8'h08, 32'hffffffff);
      wr(8'h0c, 32'hffffffff);
      em = '0;
      ev(0, k + 3, ch);
      ev(0, (k + 1) % 3 + 3, ch);
    end
    w = int'(rnd() % 8);
    ev(1, 0, w);
    ev(1, 1, w);
    ev(1, 0, w);
    ev(1, 0, w);
    ev(1, 2, (w + 1) % 8);
    eq[w] = 1'b1;
    eq[(w + 1) % 8] = 1'b1;
    exp_irq++;
    cmp_all();
    wr(8'h14, 32'h0);
    wr(8'h14, 32'h1 << w);
    eq[w] = 1'b0;
    cmp_all();
    wr(8'h14, 32'hff);
    eq = '0;
    for (k = 0; k < 3; k++) begin
      w = int'(rnd() % 31) + 1;
      @(posedge clk);
      qwm[5*k +: 5] <= 5'(w);
      qcnt[5*k +: 5] <= 5'(w - 1);
      cmp_all();
      @(posedge clk);
      qcnt[5*k +: 5] <= 5'(w);
      ec[k] = 1'b1;
      exp_irq++;
      mk = 32'h11f;
      rd(8'h28 + 8'(4 * k), 32'h100 | 32'(w));
      mk = '1;
      @(posedge clk);
      qcnt[5*k +: 5] <= 5'h0;
      wr(8'h1c, 32'h0);
      cmp_all();
      wr(8'h1c, 32'h1 << k);
      ec[k] = 1'b0;
      cmp_all();
      rd(8'h28 + 8'(4 * k), 32'h0);
      @(posedge clk);
      qwm[5*k +: 5] <= 5'h1f;
    end
    @(posedge clk);
    ti <= 1'b1;
    repeat (63) @(posedge clk);
    ti <= 1'b0;
    cmp_all();
    @(posedge clk);
    ti <= 1'b1;
    @(posedge clk);
    ti <= 1'b0;
    ec[16] = 1'b1;
    exp_irq++;
    cmp_all();
    wr(8'h20, 32'h0);
    wr(8'h20, 32'h1);
    exp_irq++;
    cmp_all();
    @(posedge clk);
    tr <= 1'b1;
    repeat (64) @(posedge clk);
    tr <= 1'b0;
    wr(8'h1c, 32'h10000);
    ec = '0;
    wr(8'h20, 32'h1);
    cmp_all();
    complete_run();
  end
endmodule // defc_top_tb
